// ===== design/icpc_config.sv
`timescale 1ns/100ps

module icpc_config
  import icpc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // Register access
  input  wire icpc_pkg::icpc_wr_t     cfg_wr_i,
  output logic [31:0]                 cfg_rdata_o,
  // Machine state power-save bit
  input  wire logic                   low_power_arm_i,
  // Pins from outside
  input  wire logic                   hard_reset_in_n_i,
  input  wire logic                   quiesce_ack_n_i,
  input  wire logic                   address_retry_in_n_i,
  // Retry pin drive, high while driving
  output logic                        address_retry_o,
  output logic                        address_retry_oe_o,
  // Core asserts retry this cycle
  input  wire logic                   retry_assert_i,
  // Clock output control
  output icpc_pkg::icpc_clkout_t      clkout_mode_o,
  output logic                        clkout_drive_o,
  // Emulator trace outputs
  input  wire logic [7:0]             trace_data_i,
  output logic [7:0]                  trace_data_o,
  output logic                        trace_oe_o,
  // Power management
  output logic                        quiesce_request_n_o,
  output logic                        doze_o,
  output logic                        nap_o,
  output logic                        sleep_o,
  output logic                        snoop_clk_en_o,
  output logic                        core_clk_en_o,
  // Unit idle gating
  input  wire logic [3:0]             unit_idle_i,
  output logic [3:0]                  unit_gate_o,
  // Instruction and data cache routing
  input  wire icpc_pkg::icpc_acc_t    iacc_i,
  input  wire icpc_pkg::icpc_acc_t    dacc_i,
  output icpc_pkg::icpc_route_t       iroute_o,
  output icpc_pkg::icpc_route_t       droute_o
);
  import icpc_pkg::*;

  icpc_state_t s_reg;
  icpc_state_t s_next;
  logic [7:0]  trace_reg;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Disabled cache becomes a single-beat pass-through
  function automatic icpc_route_t route(input logic en,
                                        input icpc_acc_t a);
    icpc_route_t r;
    r.cache_use  = en & a.req;
    r.tag_use    = en & a.req;
    r.bus_req    = a.req & (~en | a.xlat_inhibit);
    r.bus_burst  = en & a.burst & ~a.xlat_inhibit;
    // Translation's inhibit, not the forced one
    r.cache_inhibit_out = a.req & a.xlat_inhibit;
    r.snoop_take = en & a.snoop;
    return r;
  endfunction

  // Clock-out mode from select bits; off during hard reset
  function automatic icpc_clkout_t clk_sel(input logic hrst,
                                           input logic b,
                                           input logic e);
    icpc_clkout_t m;
    if (hrst)
      m = ICPC_CLKOUT_OFF;
    else
      m = icpc_clkout_t'({e, b});
    return m;
  endfunction

  // ---------------------------------------------------------------
  // Power state decode
  // ---------------------------------------------------------------

  // Bit order: request, doze, nap, sleep, snoop clock, core clock
  function automatic logic [5:0] pwr_decode(input icpc_pwr_t p);
    logic [5:0] f;
    f = 6'h03;
    case (p)
      ICPC_PWR_RUN:
      begin
        // Everything clocked
        f = 6'h03;
      end
      ICPC_PWR_DOZE:
      begin
        // Core stopped, snooping still served
        f = 6'h12;
      end
      ICPC_PWR_NAP:
      begin
        // Only the timebase side keeps running
        f = 6'h08;
      end
      ICPC_PWR_QUIESCE:
      begin
        // Still running while the system decides
        f = 6'h23;
      end
      ICPC_PWR_ENTER:
      begin
        // Request held; core drains its last work
        f = 6'h23;
      end
      ICPC_PWR_SLEEP:
      begin
        // Request held so the system may stop the clock
        f = 6'h24;
      end
      default:
      begin
        // Unused codes behave as run
        f = 6'h03;
      end
    endcase
    return f;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------

  // Register, synchronisers, power sequence, pin control
  always_comb
  begin
    s_next = s_reg;

    // Reserved and unused bits never store
    if (cfg_wr_i.we)
    begin
      s_next.cfg = cfg_wr_i.wdata & CFG_WRITE_MASK;
    end

    // Two flip-flops for pins; only stage 2 is read
    s_next.ack_s1  = ~quiesce_ack_n_i;
    s_next.ack_s2  = s_reg.ack_s1;
    s_next.hrst_s1 = ~hard_reset_in_n_i;
    s_next.hrst_s2 = s_reg.hrst_s1;

    s_next.clk_mode  = clk_sel(s_reg.hrst_s2,
                               s_reg.cfg[BIT_CLKOUT_SEL_B],
                               s_reg.cfg[BIT_CLKOUT_SEL_E]);
    s_next.clk_drive = (s_next.clk_mode != ICPC_CLKOUT_OFF);

    // Precharge: drive high one cycle after own assertion ends
    s_next.retry_prev = retry_assert_i;
    s_next.retry_oe   = retry_assert_i |
                        (s_reg.retry_prev &
                         ~s_reg.cfg[BIT_PRECHARGE_OFF]);

    // Power mode sequence
    case (s_reg.pwr)
      ICPC_PWR_RUN:
      begin
        s_next.cnt = '0;
        if (low_power_arm_i)
        begin
          if (s_reg.cfg[BIT_SLEEP_EN])
            s_next.pwr = ICPC_PWR_QUIESCE;
          else if (s_reg.cfg[BIT_NAP_EN])
            s_next.pwr = ICPC_PWR_NAP;
          else if (s_reg.cfg[BIT_DOZE_EN])
            s_next.pwr = ICPC_PWR_DOZE;
        end
      end
      ICPC_PWR_DOZE, ICPC_PWR_NAP:
      begin
        if (!low_power_arm_i)
          s_next.pwr = ICPC_PWR_RUN;
      end
      ICPC_PWR_QUIESCE:
      begin
        // Acknowledge is the system's decision to allow sleep
        if (!low_power_arm_i)
          s_next.pwr = ICPC_PWR_RUN;
        else if (s_reg.ack_s2)
          s_next.pwr = ICPC_PWR_ENTER;
      end
      ICPC_PWR_ENTER:
      begin
        // Short drain before gating the core
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.cnt == SLEEP_ENTRY_CYCLES - 3'h1)
          s_next.pwr = ICPC_PWR_SLEEP;
      end
      ICPC_PWR_SLEEP:
      begin
        // Clock may stop here; system handles PLL bypass first
        if (!low_power_arm_i)
          s_next.pwr = ICPC_PWR_RUN;
      end
      default:
      begin
        s_next.pwr = ICPC_PWR_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------

  // Cache enables come up zero with the rest
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_reg           <= '0;
      s_reg.cfg       <= CFG_RESET_VALUE;
      s_reg.pwr       <= ICPC_PWR_RUN;
      s_reg.clk_mode  <= ICPC_CLKOUT_OFF;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Trace data registered only when enabled
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      trace_reg <= 8'h00;
    else if (s_reg.cfg[BIT_TRACE_EN])
      trace_reg <= trace_data_i;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Register readback; reserved bits are zero by storage
  assign cfg_rdata_o = s_reg.cfg;

  assign clkout_mode_o  = s_reg.clk_mode;
  assign clkout_drive_o = s_reg.clk_drive;

  assign trace_data_o = trace_reg;
  assign trace_oe_o   = s_reg.cfg[BIT_TRACE_EN];

  // Low while asserting, high at every other time; the level
  // comes from a flop so it never leads the registered enable
  assign address_retry_o    = ~s_reg.retry_prev;
  assign address_retry_oe_o = s_reg.retry_oe;

  // Power outputs from the decoded state
  logic [5:0] pwr_flags;
  assign pwr_flags = pwr_decode(s_reg.pwr);

  assign quiesce_request_n_o = ~pwr_flags[5];
  assign doze_o              = pwr_flags[4];
  assign nap_o               = pwr_flags[3];
  assign sleep_o             = pwr_flags[2];
  // Snooping survives doze only
  assign snoop_clk_en_o      = pwr_flags[1];
  assign core_clk_en_o       = pwr_flags[0];

  // Gating only on idle units, so timing is unchanged
  assign unit_gate_o = unit_idle_i & {4{s_reg.cfg[BIT_DYN_PWR_EN]}};

  // Cache routing
  assign iroute_o = route(s_reg.cfg[BIT_ICACHE_EN], iacc_i);
  assign droute_o = route(s_reg.cfg[BIT_DCACHE_EN], dacc_i);

  // Pin not otherwise read; external restore is the system's duty
  logic retry_seen_unused;
  assign retry_seen_unused = address_retry_in_n_i;

endmodule

// ===== common/icpc_pkg.sv
package icpc_pkg;

  // ---------------------------------------------------------------
  // Configuration register field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_CLKOUT_SEL_B   = 4;
  localparam int unsigned BIT_TRACE_EN       = 5;
  localparam int unsigned BIT_CLKOUT_SEL_E   = 6;
  localparam int unsigned BIT_PRECHARGE_OFF  = 7;
  localparam int unsigned BIT_DOZE_EN        = 8;
  localparam int unsigned BIT_NAP_EN         = 9;
  localparam int unsigned BIT_SLEEP_EN       = 10;
  localparam int unsigned BIT_DYN_PWR_EN     = 11;
  localparam int unsigned BIT_ICACHE_EN      = 16;
  localparam int unsigned BIT_DCACHE_EN      = 17;

  // ---------------------------------------------------------------
  // Write mask and reset value (bits 4..11, 16..17 writable)
  // ---------------------------------------------------------------
  localparam logic [31:0] CFG_WRITE_MASK     = 32'h0003_0FF0;
  localparam logic [31:0] CFG_RESET_VALUE    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam logic [2:0]  SLEEP_ENTRY_CYCLES = 3'h4;

  // Clock-out modes from the two select bits and hard reset
  typedef enum logic [1:0]
  {
    ICPC_CLKOUT_OFF,
    ICPC_CLKOUT_CORE,
    ICPC_CLKOUT_HALF,
    ICPC_CLKOUT_BUS
  } icpc_clkout_t;

  // Power state
  typedef enum logic [2:0]
  {
    ICPC_PWR_RUN,
    ICPC_PWR_DOZE,
    ICPC_PWR_NAP,
    ICPC_PWR_QUIESCE,
    ICPC_PWR_ENTER,
    ICPC_PWR_SLEEP
  } icpc_pwr_t;

  // Software write port
  typedef struct packed
  {
    logic        we;
    logic [31:0] wdata;
  } icpc_wr_t;

  // Per-cache access request from the core
  typedef struct packed
  {
    logic req;
    logic burst;
    logic xlat_inhibit;
    logic snoop;
  } icpc_acc_t;

  // Per-cache routed access
  typedef struct packed
  {
    logic cache_use;
    logic tag_use;
    logic bus_req;
    logic bus_burst;
    logic cache_inhibit_out;
    logic snoop_take;
  } icpc_route_t;

  // All module state except the trace data register
  typedef struct packed
  {
    logic [31:0]  cfg;
    icpc_pwr_t    pwr;
    logic [2:0]   cnt;
    logic         ack_s1;
    logic         ack_s2;
    logic         hrst_s1;
    logic         hrst_s2;
    icpc_clkout_t clk_mode;
    logic         clk_drive;
    logic         retry_oe;
    logic         retry_prev;
  } icpc_state_t;

endpackage

// ===== verif/icpc_sys_model.sv
`timescale 1ns/100ps
// --------------------
// System logic model
// --------------------
module icpc_sys_model
(
  // Clock, reset and pace
  input  wire logic clk_i, nrst_i, slow_i,
  // Processor side
  input  wire logic quiesce_request_n_i,
  input  wire logic address_retry_i, address_retry_oe_i,
  // Levels returned to the processor
  output logic      quiesce_ack_n_o,
  output logic      address_retry_n_o
);
  logic [3:0] wait_cnt;

  // Age of the standing request; slow pace delays the grant
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i || quiesce_request_n_i)
      wait_cnt <= 4'h0;
    else if (wait_cnt != 4'hF)
      wait_cnt <= wait_cnt + 4'h1;
  end

  // Sleep never stops the clock here, so no bypass is owed
  // Grant only after a request has been seen
  assign quiesce_ack_n_o = !(wait_cnt > (slow_i ? 4'h6 : 4'h0));
  // Released line pulled back high by the system
  assign address_retry_n_o = address_retry_oe_i ? address_retry_i : 1'b1;
endmodule

// ===== verif/icpc_config_checker.sv
`timescale 1ns/100ps
// --------------------
// Port checker
// --------------------
module icpc_config_checker
  import icpc_pkg::*;
(
  // Clock, reset and stimulus
  input wire logic                   clk_i, nrst_i,
  input wire icpc_pkg::icpc_wr_t     cfg_wr_i,
  input wire logic                   low_power_arm_i, quiesce_ack_n_i,
  input wire logic                   hard_reset_in_n_i, retry_assert_i,
  input wire icpc_pkg::icpc_acc_t    iacc_i, dacc_i,
  // Design outputs
  input wire logic [31:0]            cfg_rdata_o,
  input wire logic                   address_retry_o, address_retry_oe_o,
  input wire icpc_pkg::icpc_clkout_t clkout_mode_o,
  input wire logic                   clkout_drive_o, trace_oe_o, doze_o,
  input wire logic                   quiesce_request_n_o, nap_o, sleep_o,
  input wire logic                   snoop_clk_en_o,
  input wire icpc_pkg::icpc_route_t  iroute_o, droute_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Arm is only taken from the run state
  wire logic run = quiesce_request_n_o && !doze_o && !nap_o && !sleep_o;
  wire logic arm = low_power_arm_i && run;

  // Route of a disabled cache
  function automatic icpc_route_t off_rt(input icpc_acc_t a);
    return {2'b00, a.req, 1'b0, a.req & a.xlat_inhibit, 1'b0};
  endfunction

  AST_WR: assert property (
    cfg_wr_i.we |=> cfg_rdata_o == ($past(cfg_wr_i.wdata) & CFG_WRITE_MASK))
    else $error("config write not taken");
  AST_TRACE: assert property (
    trace_oe_o == cfg_rdata_o[BIT_TRACE_EN]) else $error("trace enable");
  AST_ICOFF: assert property (
    !cfg_rdata_o[BIT_ICACHE_EN] |-> iroute_o == off_rt(iacc_i))
    else $error("disabled icache route");
  AST_DCOFF: assert property (
    !cfg_rdata_o[BIT_DCACHE_EN] |-> droute_o == off_rt(dacc_i))
    else $error("disabled dcache route");
  AST_QUIESCE_REQUEST: assert property (
    arm && cfg_rdata_o[BIT_SLEEP_EN] |=> !quiesce_request_n_o)
    else $error("no quiesce request");
  AST_NAP: assert property (
    arm && cfg_rdata_o[10:9] == 2'b01 |=> nap_o && !snoop_clk_en_o)
    else $error("nap not entered");
  AST_DOZE: assert property (
    arm && cfg_rdata_o[10:8] == 3'b001 |=> doze_o && snoop_clk_en_o)
    else $error("doze not entered");
  AST_SLEEP: assert property (
    (!quiesce_request_n_o && !quiesce_ack_n_i && low_power_arm_i)[*8]
    |-> ##[0:3] sleep_o) else $error("sleep not entered");
  AST_RTY: assert property (
    $fell(retry_assert_i) && !cfg_rdata_o[BIT_PRECHARGE_OFF]
    |=> address_retry_oe_o && address_retry_o)
    else $error("no retry precharge");
  AST_RTY_OFF: assert property (
    cfg_rdata_o[BIT_PRECHARGE_OFF]
    |=> !(address_retry_oe_o && address_retry_o))
    else $error("retry driven high with precharge off");
  AST_CLK: assert property (
    ($stable(cfg_rdata_o) && hard_reset_in_n_i)[*4] |->
    clkout_mode_o == {cfg_rdata_o[BIT_CLKOUT_SEL_E], cfg_rdata_o[4]}
    && clkout_drive_o == (clkout_mode_o != ICPC_CLKOUT_OFF))
    else $error("clock out mode");

  // Main scenarios reached
  cover property (sleep_o);
  cover property (nap_o);
  cover property ($fell(retry_assert_i) && !cfg_rdata_o[7]);
endmodule

bind icpc_config icpc_config_checker u_chk
(
  .clk_i               (clk_i),
  .nrst_i              (nrst_i),
  .cfg_wr_i            (cfg_wr_i),
  .low_power_arm_i     (low_power_arm_i),
  .quiesce_ack_n_i     (quiesce_ack_n_i),
  .hard_reset_in_n_i   (hard_reset_in_n_i),
  .retry_assert_i      (retry_assert_i),
  .iacc_i              (iacc_i),
  .dacc_i              (dacc_i),
  .cfg_rdata_o         (cfg_rdata_o),
  .address_retry_o     (address_retry_o),
  .address_retry_oe_o  (address_retry_oe_o),
  .clkout_mode_o       (clkout_mode_o),
  .clkout_drive_o      (clkout_drive_o),
  .trace_oe_o          (trace_oe_o),
  .doze_o              (doze_o),
  .quiesce_request_n_o (quiesce_request_n_o),
  .nap_o               (nap_o),
  .sleep_o             (sleep_o),
  .snoop_clk_en_o      (snoop_clk_en_o),
  .iroute_o            (iroute_o),
  .droute_o            (droute_o)
);

// ===== verif/tb.sv
`timescale 1ns/100ps
// --------------------
// Bench
// --------------------
module tb;
  import icpc_pkg::*;
  logic clk_i, nrst_i, low_power_arm_i, hard_reset_in_n_i, retry_assert_i;
  logic quiesce_ack_n_i, address_retry_in_n_i, address_retry_o, slow;
  logic address_retry_oe_o, clkout_drive_o, trace_oe_o, quiesce_request_n_o;
  logic doze_o, nap_o, sleep_o, snoop_clk_en_o, core_clk_en_o;
  logic [31:0] cfg_rdata_o, seed, cfg;
  logic [7:0] trace_data_i, trace_data_o, tr_q;
  logic [3:0] unit_idle_i, unit_gate_o;
  icpc_wr_t cfg_wr_i;
  icpc_acc_t iacc_i, dacc_i;
  icpc_route_t iroute_o, droute_o;
  icpc_clkout_t clkout_mode_o;
  int bad_count, total_checks, cyc;

  icpc_config u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rdata_o(cfg_rdata_o),
    .low_power_arm_i(low_power_arm_i),
    .hard_reset_in_n_i(hard_reset_in_n_i),
    .quiesce_ack_n_i(quiesce_ack_n_i),
    .address_retry_in_n_i(address_retry_in_n_i),
    .address_retry_o(address_retry_o),
    .address_retry_oe_o(address_retry_oe_o),
    .retry_assert_i(retry_assert_i),
    .clkout_mode_o(clkout_mode_o), .clkout_drive_o(clkout_drive_o),
    .trace_data_i(trace_data_i), .trace_data_o(trace_data_o),
    .trace_oe_o(trace_oe_o),
    .quiesce_request_n_o(quiesce_request_n_o),
    .doze_o(doze_o), .nap_o(nap_o), .sleep_o(sleep_o),
    .snoop_clk_en_o(snoop_clk_en_o), .core_clk_en_o(core_clk_en_o),
    .unit_idle_i(unit_idle_i), .unit_gate_o(unit_gate_o),
    .iacc_i(iacc_i), .dacc_i(dacc_i),
    .iroute_o(iroute_o), .droute_o(droute_o));
  icpc_sys_model u_sys (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow),
    .quiesce_request_n_i(quiesce_request_n_o),
    .address_retry_i(address_retry_o), .address_retry_oe_i(address_retry_oe_o),
    .quiesce_ack_n_o(quiesce_ack_n_i), .address_retry_n_o(address_retry_in_n_i));

  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected route of an enabled or a disabled cache, every field
  function automatic logic [5:0] rt(input logic en, input icpc_acc_t a);
    if (en)
      return {a.req, a.req, a.req & a.xlat_inhibit,
              a.burst & ~a.xlat_inhibit, a.req & a.xlat_inhibit, a.snoop};
    return {2'b00, a.req, 1'b0, a.req & a.xlat_inhibit, 1'b0};
  endfunction

  // Check last cycle against the model, then drive the next
  task automatic step(input logic we, input logic [31:0] d);
    logic [31:0] r;
    @(negedge clk_i);
    chk("cfg", cfg_rdata_o, cfg);
    chk("trace_oe", trace_oe_o, cfg[5]);
    chk("trace", trace_data_o, tr_q);
    chk("gate", unit_gate_o, unit_idle_i & {4{cfg[11]}});
    chk("ir", iroute_o, rt(cfg[16], iacc_i));
    chk("dr", droute_o, rt(cfg[17], dacc_i));
    r = rnd();
    if (cfg[5])
      tr_q = r[7:0];
    if (we)
      cfg = d & CFG_WRITE_MASK;
    cfg_wr_i = '{we, d};
    {iacc_i, dacc_i, unit_idle_i, trace_data_i} = r[19:0];
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      close_out();
    end
  end

  initial
  begin
    logic [31:0] r;
    logic [1:0] e;
    int m;
    seed = 32'h67F2;
    {nrst_i, low_power_arm_i, retry_assert_i, slow, cfg, tr_q} = '0;
    {cfg_wr_i, iacc_i, dacc_i, unit_idle_i, trace_data_i} = '0;
    hard_reset_in_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    chk("ic_en", cfg_rdata_o[16], 1'b0);
    chk("dc_en", cfg_rdata_o[17], 1'b0);
    // Back-to-back writes, every clock-out code, hard reset
    for (int i = 0; i < 8; i++)
    begin
      hard_reset_in_n_i = !i[2];
      r = rnd();
      r[4] = i[0];
      r[6] = i[1];
      step(1'b1, rnd());
      step(1'b1, r);
      repeat (4) step(1'b0, 0);
      e = i[2] ? 2'b00 : i[1:0];
      chk("clk_mode", clkout_mode_o, e);
      chk("clk_drive", clkout_drive_o, e != 2'b00);
    end
    hard_reset_in_n_i = 1'b1;
    // Doze, nap, then sleep granted promptly and slowly
    for (int k = 0; k < 4; k++)
    begin
      m = (k > 2) ? 2 : k;
      slow = (k == 3);
      step(1'b1, 32'h100 << m);
      step(1'b0, 0);
      low_power_arm_i = 1'b1;
      repeat (2) step(1'b0, 0);
      chk("doze", doze_o, m == 0);
      chk("nap", nap_o, m == 1);
      chk("quiesce_request_n", quiesce_request_n_o, m != 2);
      chk("snoop_en", snoop_clk_en_o, m != 1);
      for (int w = 0; w < 30 && m == 2 && sleep_o !== 1'b1; w++)
        step(1'b0, 0);
      chk("sleep", sleep_o, m == 2);
      chk("core_en", core_clk_en_o, 1'b0);
      low_power_arm_i = 1'b0;
      repeat (2) step(1'b0, 0);
      chk("run", {quiesce_request_n_o, core_clk_en_o}, 2'b11);
    end
    // Retry with precharge on, then off
    for (int b = 0; b < 2; b++)
    begin
      step(1'b1, b << 7);
      retry_assert_i = 1'b1;
      step(1'b0, 0);
      chk("retry_low", address_retry_in_n_i, 1'b0);
      retry_assert_i = 1'b0;
      step(1'b0, 0);
      chk("retry_oe", address_retry_oe_o, b == 0);
      chk("retry_lvl", address_retry_in_n_i, 1'b1);
    end
    close_out();
  end
endmodule
